// >>> spi_cmd_pkg.sv
package spi_cmd_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned WC_TIME_MS     = 5;
    localparam int unsigned WC_CYCLES      = WC_TIME_MS * 1000 * CLK_MHZ;

    // ****************************************
    // Opcode fields
    // ****************************************
    localparam int unsigned ADDR_W         = 9;
    localparam int unsigned OP_A8_BIT      = 3;
    localparam logic [3:0]  OP_HI_NIBBLE   = 4'h0;
    localparam logic [2:0]  OPL_ENABLE     = 3'h6;
    localparam logic [2:0]  OPL_DISABLE    = 3'h4;
    localparam logic [2:0]  OPL_SR_READ    = 3'h5;
    localparam logic [2:0]  OPL_SR_WRITE   = 3'h1;
    localparam logic [2:0]  OPL_ARR_READ   = 3'h3;
    localparam logic [2:0]  OPL_ARR_WRITE  = 3'h2;
    localparam int unsigned PAGE_BITS      = 3;

    // ****************************************
    // Status register layout
    // ****************************************
    localparam int unsigned SR_BUSY_BIT    = 0;
    localparam int unsigned SR_WEL_BIT     = 1;
    localparam int unsigned SR_BP_LO_BIT   = 2;
    localparam int unsigned SR_BP_HI_BIT   = 3;
    localparam logic [7:0]  SR_BUSY_VALUE  = 8'hff;
    localparam logic [1:0]  BP_RESET       = 2'h0;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_OPCODE = 8'h02,
        ST_ADDR   = 8'h04,
        ST_RDATA  = 8'h08,
        ST_WDATA  = 8'h10,
        ST_SR_RD  = 8'h20,
        ST_SR_WR  = 8'h40,
        ST_IGNORE = 8'h80
    } seq_state_t;

    typedef enum logic [2:0] {
        CMD_BAD   = 3'h0,
        CMD_WEN   = 3'h1,
        CMD_WDIS  = 3'h2,
        CMD_SRRD  = 3'h3,
        CMD_SRWR  = 3'h4,
        CMD_READ  = 3'h5,
        CMD_WRITE = 3'h6
    } cmd_t;

endpackage

// >>> pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned W         = 1,
    parameter logic [W-1:0] RST_VAL  = '0
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         ce_i,
    // Pins
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else if (ce_i) begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule

// >>> byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             ce_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_ff != (PW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_ff[rd_ptr_ff];

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else if (ce_i && push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (ce_i) begin
            if (push) begin
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule

// >>> spi_cmd_front.sv
`timescale 1ns/1ps
module spi_cmd_front #(
    parameter int unsigned WC_CYCLES  = spi_cmd_pkg::WC_CYCLES,
    parameter int unsigned FIFO_DEPTH = 4
) (
    // Clock, reset, enable
    input  wire logic                           ref_clk_i,
    input  wire logic                           arst_n_i,
    input  wire logic                           ce_i,
    // Serial pins
    input  wire logic                           cs_n_i,
    input  wire logic                           sck_i,
    input  wire logic                           si_i,
    input  wire logic                           hold_n_i,
    input  wire logic                           wp_n_i,
    output logic                                so_o,
    output logic                                so_oe_o,
    // Array read port
    output logic      [spi_cmd_pkg::ADDR_W-1:0] mem_rd_addr_o,
    input  wire logic [7:0]                     mem_rd_data_i,
    // Array write stream
    output logic                                wr_valid_o,
    input  wire logic                           wr_ready_i,
    output logic      [spi_cmd_pkg::ADDR_W-1:0] wr_addr_o,
    output logic      [7:0]                     wr_data_o,
    output logic                                wr_commit_o,
    output logic                                wr_abort_o,
    output logic                                wr_overrun_o,
    // Status
    output logic                                busy_o,
    output logic                                wel_o,
    output logic      [1:0]                     block_protect_o
);

    localparam int unsigned AW    = spi_cmd_pkg::ADDR_W;
    localparam int unsigned CNT_W = $clog2(WC_CYCLES + 1);
    localparam int unsigned PB    = spi_cmd_pkg::PAGE_BITS;

    // ****************************************
    // Pin synchronisers and edges
    // ****************************************
    logic [4:0]              pins_s;
    logic                    cs_n_s;
    logic                    sck_s;
    logic                    si_s;
    logic                    hold_n_s;
    logic                    wp_n_s;
    logic                    sck_d_ff;
    logic                    cs_d_ff;
    logic                    sck_rise;
    logic                    sck_fall;
    logic                    cs_fall;
    logic                    cs_rise;

    pin_sync #(
        .W       (5),
        .RST_VAL (5'h1d)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .ce_i      (ce_i),
        .async_i   ({cs_n_i, hold_n_i, wp_n_i, sck_i, si_i}),
        .sync_o    (pins_s)
    );

    assign {cs_n_s, hold_n_s, wp_n_s, sck_s, si_s} = pins_s;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
        end else if (ce_i) begin
            sck_d_ff <= sck_s;
            cs_d_ff  <= cs_n_s;
        end
    end

    assign sck_rise = sck_s & ~sck_d_ff;
    assign sck_fall = ~sck_s & sck_d_ff;
    assign cs_fall  = ~cs_n_s & cs_d_ff;
    assign cs_rise  = cs_n_s & ~cs_d_ff;

    // ****************************************
    // Pause
    // ****************************************
    logic                    paused_ff;
    logic                    rx_edge;
    logic                    tx_edge;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            paused_ff <= 1'b0;
        end else if (ce_i) begin
            if (cs_n_s) begin
                paused_ff <= 1'b0;
            end else if (!sck_s) begin
                paused_ff <= ~hold_n_s;
            end
        end
    end

    assign rx_edge = sck_rise & ~cs_n_s & ~paused_ff;
    assign tx_edge = sck_fall & ~cs_n_s & ~paused_ff;

    // ****************************************
    // Receive shifter and decode
    // ****************************************
    spi_cmd_pkg::seq_state_t state_ff;
    spi_cmd_pkg::seq_state_t nxt_state;
    spi_cmd_pkg::cmd_t       op_cmd;
    logic [2:0]              bit_cnt_ff;
    logic [7:0]              rx_sh_ff;
    logic [7:0]              rx_byte;
    logic                    byte_done;
    logic                    is_rd_ff;
    logic [AW-1:0]           addr_ff;
    logic                    wel_ff;
    logic                    busy_ff;
    logic [CNT_W-1:0]        busy_cnt_ff;
    logic                    busy_end;
    logic [1:0]              bp_ff;
    logic [1:0]              bp_pend_ff;
    logic                    sr_pend_ff;
    logic                    wr_pend_ff;
    logic                    wp_drop_ff;
    logic                    go;
    logic                    push;
    logic                    push_ready;

    assign rx_byte   = {rx_sh_ff[6:0], si_s};
    assign byte_done = rx_edge & (bit_cnt_ff == 3'h7);

    function automatic spi_cmd_pkg::cmd_t decode_op(input logic [7:0] op, input logic busy);
        spi_cmd_pkg::cmd_t c;
        c = spi_cmd_pkg::CMD_BAD;
        if (op[7:4] == spi_cmd_pkg::OP_HI_NIBBLE) begin
            unique case (op[2:0])
                spi_cmd_pkg::OPL_ENABLE:    c = spi_cmd_pkg::CMD_WEN;
                spi_cmd_pkg::OPL_DISABLE:   c = spi_cmd_pkg::CMD_WDIS;
                spi_cmd_pkg::OPL_SR_READ:   c = spi_cmd_pkg::CMD_SRRD;
                spi_cmd_pkg::OPL_SR_WRITE:  c = spi_cmd_pkg::CMD_SRWR;
                spi_cmd_pkg::OPL_ARR_READ:  c = spi_cmd_pkg::CMD_READ;
                spi_cmd_pkg::OPL_ARR_WRITE: c = spi_cmd_pkg::CMD_WRITE;
                default:                    c = spi_cmd_pkg::CMD_BAD;
            endcase
        end
        if (busy && c != spi_cmd_pkg::CMD_SRRD) begin
            c = spi_cmd_pkg::CMD_BAD;
        end
        decode_op = c;
    endfunction

    assign op_cmd = decode_op(rx_byte, busy_ff);

    always_comb begin
        nxt_state = state_ff;
        if (cs_n_s) begin
            nxt_state = spi_cmd_pkg::ST_IDLE;
        end else if (cs_fall) begin
            nxt_state = spi_cmd_pkg::ST_OPCODE;
        end else if (byte_done) begin
            unique case (state_ff)
                spi_cmd_pkg::ST_OPCODE: begin
                    unique case (op_cmd)
                        spi_cmd_pkg::CMD_SRRD:  nxt_state = spi_cmd_pkg::ST_SR_RD;
                        spi_cmd_pkg::CMD_READ:  nxt_state = spi_cmd_pkg::ST_ADDR;
                        spi_cmd_pkg::CMD_SRWR: begin
                            nxt_state = (wel_ff & wp_n_s) ? spi_cmd_pkg::ST_SR_WR
                                                          : spi_cmd_pkg::ST_IGNORE;
                        end
                        spi_cmd_pkg::CMD_WRITE: begin
                            nxt_state = (wel_ff & wp_n_s) ? spi_cmd_pkg::ST_ADDR
                                                          : spi_cmd_pkg::ST_IGNORE;
                        end
                        default:                nxt_state = spi_cmd_pkg::ST_IGNORE;
                    endcase
                end
                spi_cmd_pkg::ST_ADDR: begin
                    nxt_state = is_rd_ff ? spi_cmd_pkg::ST_RDATA : spi_cmd_pkg::ST_WDATA;
                end
                spi_cmd_pkg::ST_SR_WR:  nxt_state = spi_cmd_pkg::ST_IGNORE;
                default:                nxt_state = state_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff   <= spi_cmd_pkg::ST_IDLE;
            bit_cnt_ff <= 3'h0;
            rx_sh_ff   <= 8'h00;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            if (cs_fall) begin
                bit_cnt_ff <= 3'h0;
            end else if (rx_edge && state_ff != spi_cmd_pkg::ST_IGNORE) begin
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                rx_sh_ff   <= rx_byte;
            end
        end
    end

    // ****************************************
    // Address pointer
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            is_rd_ff <= 1'b0;
            addr_ff  <= '0;
        end else if (ce_i && byte_done) begin
            unique case (state_ff)
                spi_cmd_pkg::ST_OPCODE: begin
                    is_rd_ff    <= (op_cmd == spi_cmd_pkg::CMD_READ);
                    addr_ff[AW-1] <= rx_byte[spi_cmd_pkg::OP_A8_BIT];
                end
                spi_cmd_pkg::ST_ADDR:  addr_ff[7:0] <= rx_byte;
                spi_cmd_pkg::ST_RDATA: addr_ff <= addr_ff + 1'b1;
                spi_cmd_pkg::ST_WDATA: addr_ff[PB-1:0] <= addr_ff[PB-1:0] + 1'b1;
                default:               addr_ff <= addr_ff;
            endcase
        end
    end

    assign mem_rd_addr_o = addr_ff;

    // ****************************************
    // Write-enable latch and protect bits
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wel_ff <= 1'b0;
        end else if (ce_i) begin
            if (busy_end) begin
                wel_ff <= 1'b0;
            end else if (byte_done && state_ff == spi_cmd_pkg::ST_OPCODE) begin
                if (op_cmd == spi_cmd_pkg::CMD_WEN) begin
                    wel_ff <= 1'b1;
                end else if (op_cmd == spi_cmd_pkg::CMD_WDIS) begin
                    wel_ff <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bp_ff      <= spi_cmd_pkg::BP_RESET;
            bp_pend_ff <= spi_cmd_pkg::BP_RESET;
            sr_pend_ff <= 1'b0;
        end else if (ce_i) begin
            if (cs_fall) begin
                sr_pend_ff <= 1'b0;
            end else if (byte_done && state_ff == spi_cmd_pkg::ST_SR_WR) begin
                bp_pend_ff <= rx_byte[spi_cmd_pkg::SR_BP_HI_BIT:spi_cmd_pkg::SR_BP_LO_BIT];
                sr_pend_ff <= 1'b1;
            end
            if (cs_rise && go && sr_pend_ff) begin
                bp_ff <= bp_pend_ff;
            end
        end
    end

    // ****************************************
    // Write commit, abort and busy interval
    // ****************************************
    assign go = cs_rise & (wr_pend_ff | sr_pend_ff) & wel_ff & wp_n_s & ~wp_drop_ff;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_pend_ff  <= 1'b0;
            wp_drop_ff  <= 1'b0;
            wr_commit_o <= 1'b0;
            wr_abort_o  <= 1'b0;
        end else if (ce_i) begin
            wr_commit_o <= go;
            wr_abort_o  <= cs_rise & (wr_pend_ff | sr_pend_ff) & ~go;
            if (cs_fall) begin
                wr_pend_ff <= 1'b0;
                wp_drop_ff <= 1'b0;
            end else begin
                if (byte_done && state_ff == spi_cmd_pkg::ST_WDATA) begin
                    wr_pend_ff <= 1'b1;
                end
                if (!cs_n_s && !wp_n_s) begin
                    wp_drop_ff <= 1'b1;
                end
            end
        end
    end

    assign busy_end = busy_ff & (busy_cnt_ff == '0);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_ff     <= 1'b0;
            busy_cnt_ff <= '0;
        end else if (ce_i) begin
            if (go) begin
                busy_ff     <= 1'b1;
                busy_cnt_ff <= CNT_W'(WC_CYCLES - 1);
            end else if (busy_end) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                busy_cnt_ff <= busy_cnt_ff - 1'b1;
            end
        end
    end

    // ****************************************
    // Transmit shifter
    // ****************************************
    logic [7:0] status;
    logic [7:0] so_sh_ff;
    logic       so_oe_ff;
    logic       tx_state;

    always_comb begin
        status = 8'h00;
        status[spi_cmd_pkg::SR_BUSY_BIT] = busy_ff;
        status[spi_cmd_pkg::SR_WEL_BIT]  = wel_ff;
        status[spi_cmd_pkg::SR_BP_HI_BIT:spi_cmd_pkg::SR_BP_LO_BIT] = bp_ff;
        if (busy_ff) begin
            status = spi_cmd_pkg::SR_BUSY_VALUE;
        end
    end

    assign tx_state = (state_ff == spi_cmd_pkg::ST_RDATA) | (state_ff == spi_cmd_pkg::ST_SR_RD);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            so_sh_ff <= 8'h00;
            so_oe_ff <= 1'b0;
        end else if (ce_i) begin
            if (cs_n_s || !tx_state) begin
                so_oe_ff <= 1'b0;
            end else if (tx_edge) begin
                if (bit_cnt_ff == 3'h0) begin
                    so_sh_ff <= (state_ff == spi_cmd_pkg::ST_RDATA) ? mem_rd_data_i : status;
                    so_oe_ff <= 1'b1;
                end else begin
                    so_sh_ff <= {so_sh_ff[6:0], 1'b0};
                end
            end
        end
    end

    assign so_o    = so_sh_ff[7];
    assign so_oe_o = so_oe_ff & ~paused_ff;

    // ****************************************
    // Write stream buffer
    // ****************************************
    logic overrun_ff;

    assign push = byte_done & (state_ff == spi_cmd_pkg::ST_WDATA);

    byte_fifo #(
        .WIDTH (AW + 8),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .ref_clk_i   (ref_clk_i),
        .arst_n_i    (arst_n_i),
        .ce_i        (ce_i),
        .in_valid_i  (push),
        .in_ready_o  (push_ready),
        .in_data_i   ({addr_ff, rx_byte}),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  ({wr_addr_o, wr_data_o})
    );

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            overrun_ff <= 1'b0;
        end else if (ce_i) begin
            if (push && !push_ready) begin
                overrun_ff <= 1'b1;
            end else if (cs_fall) begin
                overrun_ff <= 1'b0;
            end
        end
    end

    assign wr_overrun_o    = overrun_ff;
    assign busy_o          = busy_ff;
    assign wel_o           = wel_ff;
    assign block_protect_o = bp_ff;

endmodule

// >>> spi_cmd_monitor.sv
`timescale 1ns/1ps
module spi_cmd_monitor #(
    parameter int unsigned WC_CYCLES = 20
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic hold_n_i,
    input wire logic so_oe_o,
    // Write and status
    input wire logic wr_commit_o,
    input wire logic wr_abort_o,
    input wire logic busy_o,
    input wire logic wel_o
);
    int unsigned busy_len_ff;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    // Length of current busy run
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) busy_len_ff <= '0;
        else busy_len_ff <= busy_o ? busy_len_ff + 1 : '0;
    end

    sequence s_busy_soon;
        ##[0:1] busy_o;
    endsequence
    sequence s_no_start;
        !wr_commit_o ##1 !busy_o;
    endsequence

    property p_desel_quiet;
        cs_n_i [*4] |-> !so_oe_o;
    endproperty
    property p_pause_quiet;
        (!hold_n_i && !sck_i) [*5] |-> !so_oe_o;
    endproperty
    property p_commit_busy;
        wr_commit_o |-> s_busy_soon;
    endproperty
    property p_busy_len;
        $fell(busy_o) |-> busy_len_ff == WC_CYCLES;
    endproperty
    property p_end_clears_wel;
        $fell(busy_o) |-> !wel_o;
    endproperty
    property p_busy_no_wel;
        busy_o && $past(busy_o) |-> !$rose(wel_o);
    endproperty
    property p_abort_no_start;
        wr_abort_o |-> s_no_start;
    endproperty
    property p_commit_wel;
        wr_commit_o |-> wel_o;
    endproperty

    a_desel_quiet: assert property (p_desel_quiet) else $error("so on while deselected");
    a_pause_quiet: assert property (p_pause_quiet) else $error("so on while paused");
    a_commit_busy: assert property (p_commit_busy) else $error("commit without busy");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_end_clears_wel: assert property (p_end_clears_wel) else $error("latch kept");
    a_busy_no_wel: assert property (p_busy_no_wel) else $error("latch set while busy");
    a_abort_no_start: assert property (p_abort_no_start) else $error("aborted write ran");
    a_commit_wel: assert property (p_commit_wel) else $error("commit with latch clear");
endmodule

// >>> spi_host.sv
`timescale 1ns/1ps
module spi_host (
    // Clock
    input  wire logic ref_clk_i,
    // Serial pins
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    output logic      hold_n_o,
    output logic      wp_n_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b1;
        hold_n_o = 1'b1;
        wp_n_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic sel(input logic lvl);
        tick(4);
        cs_n_o <= lvl;
        tick(5);
    endtask

    // Called only with clock low
    task automatic pins(input logic wp, input logic hold);
        tick(2);
        wp_n_o <= wp;
        hold_n_o <= hold;
        tick(2);
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o <= tx[i];
            tick(5);
            rx[i] = so_oe_i ? so_i : 1'bx;
            sck_o <= 1'b1;
            tick(5);
            sck_o <= 1'b0;
        end
        tick(1);
        si_o <= ~si_o;
        tick(1);
    endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned WC = 400;
    logic       ref_clk_i;
    logic       arst_n_i;
    logic       ce = 1'b1;
    logic       cs_n, sck, si, hold_n, wp_n, so, so_oe, wr_ready, wr_valid;
    logic       wr_commit, wr_abort, wr_overrun, busy, wel;
    logic [8:0] rd_addr, wr_addr;
    logic [7:0] wr_data, rx, rd_data;
    logic [1:0] bp;
    int         errors = 0, checks_done = 0, cycles = 0, commits = 0, aborts = 0;

    assign rd_data = rd_addr[7:0] ^ 8'ha5;

    spi_host i_spi_host (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
        .hold_n_o(hold_n), .wp_n_o(wp_n), .so_i(so), .so_oe_i(so_oe));
    spi_cmd_front #(.WC_CYCLES(WC), .FIFO_DEPTH(4)) i_spi_cmd_front (.ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i), .ce_i(ce), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe),
        .mem_rd_addr_o(rd_addr), .mem_rd_data_i(rd_data),
        .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .wr_commit_o(wr_commit), .wr_abort_o(wr_abort),
        .wr_overrun_o(wr_overrun), .busy_o(busy), .wel_o(wel), .block_protect_o(bp));

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        commits += int'(wr_commit === 1'b1);
        aborts += int'(wr_abort === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic frame(input logic [7:0] q[$]);
        i_spi_host.sel(1'b0);
        foreach (q[k]) i_spi_host.xfer(q[k], rx);
        i_spi_host.sel(1'b1);
    endtask

    task automatic status_is(input logic [7:0] exp);
        frame('{8'h05, 8'h00});
        check("status", rx, exp);
    endtask

    task automatic pop();
        wr_ready <= 1'b1;
        @(posedge ref_clk_i);
        wr_ready <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask

    task automatic until_idle();
        for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge ref_clk_i);
        check("busy", busy, 1'b0);
    endtask

    task automatic t_latch();
        status_is(8'h00);
        frame('{8'h0e});
        status_is(8'h02);
        i_spi_host.pins(1'b0, 1'b1);
        frame('{8'h0c});
        i_spi_host.pins(1'b1, 1'b1);
        status_is(8'h00);
        ce <= 1'b0;
        frame('{8'h0e});
        ce <= 1'b1;
        status_is(8'h00);
        $display("t_latch done");
    endtask

    task automatic t_bad();
        logic [7:0] ops [3] = '{8'h75, 8'h07, 8'h00};
        foreach (ops[k]) begin
            frame('{ops[k], 8'h05, 8'h00});
            check("so", rx, 8'hxx);
        end
        $display("t_bad done");
    endtask

    task automatic t_write();
        frame('{8'h06});
        frame('{8'h02, 8'h05, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34});
        check("commit", commits, 1);
        check("overrun", wr_overrun, 1'b1);
        status_is(8'hff);
        frame('{8'h06});
        until_idle();
        status_is(8'h00);
        for (int i = 0; i < 4; i++) begin
            check("addr", wr_addr, 9'(5 + i) & 9'h007);
            check("data", wr_data, 8'(8'h30 + i));
            pop();
        end
        check("valid", wr_valid, 1'b0);
        $display("t_write done");
    endtask

    task automatic t_abort();
        frame('{8'h06});
        i_spi_host.sel(1'b0);
        i_spi_host.xfer(8'h02, rx);
        i_spi_host.xfer(8'h10, rx);
        i_spi_host.xfer(8'h55, rx);
        i_spi_host.pins(1'b0, 1'b1);
        i_spi_host.sel(1'b1);
        check("abort", aborts, 1);
        check("commit", commits, 1);
        check("busy", busy, 1'b0);
        i_spi_host.pins(1'b1, 1'b1);
        pop();
        $display("t_abort done");
    endtask

    task automatic t_srw();
        frame('{8'h06});
        frame('{8'h09, 8'h0c});
        until_idle();
        check("bp", bp, 2'h3);
        status_is(8'h0c);
        frame('{8'h06});
        arst_n_i <= 1'b0;
        i_spi_host.tick(4);
        arst_n_i <= 1'b1;
        i_spi_host.tick(4);
        status_is(8'h00);
        $display("t_srw done");
    endtask

    task automatic t_read();
        i_spi_host.sel(1'b0);
        i_spi_host.xfer(8'h0b, rx);
        i_spi_host.xfer(8'hff, rx);
        i_spi_host.xfer(8'h00, rx);
        check("rd0", rx, 8'h5a);
        i_spi_host.pins(1'b1, 1'b0);
        i_spi_host.tick(20);
        check("so_oe", so_oe, 1'b0);
        i_spi_host.xfer(8'hff, rx);
        check("so", rx, 8'hxx);
        i_spi_host.pins(1'b1, 1'b1);
        i_spi_host.xfer(8'h00, rx);
        check("rd1", rx, 8'ha5);
        i_spi_host.sel(1'b1);
        $display("t_read done");
    endtask

    initial begin
        arst_n_i = 1'b0;
        wr_ready = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        t_latch();
        t_bad();
        t_write();
        t_abort();
        t_srw();
        t_read();
        complete_run();
    end
endmodule

bind spi_cmd_front spi_cmd_monitor #(.WC_CYCLES(WC_CYCLES)) i_spi_cmd_monitor (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
    .hold_n_i(hold_n_i), .so_oe_o(so_oe_o), .wr_commit_o(wr_commit_o),
    .wr_abort_o(wr_abort_o), .busy_o(busy_o), .wel_o(wel_o));
